// File: shared/monitor_regs_pkg.sv
// constants and types shared by the health monitor register bank
package monitor_regs_pkg;
	localparam int          ADDR_W            = 9;
	localparam int          DATA_W            = 16;
	localparam logic [8:0]  OFF_SEQ_CFG       = 9'h1e9;
	localparam logic [8:0]  OFF_READBACK      = 9'h1ea;
	localparam logic [8:0]  OFF_LOCK_PROT     = 9'h1ee;
	localparam logic [8:0]  OFF_BYPASS_CTRL   = 9'h1e8;
	localparam logic [15:0] RST_SEQ_CFG       = 16'h036d;
	localparam logic [15:0] RST_LOCK_PROT     = 16'h0035;
	localparam logic [15:0] RST_BYPASS_CTRL   = 16'h0000;
	localparam int          POS_GAIN_SRC      = 15;
	localparam int          POS_BYPASS        = 14;
	localparam int          POS_CYCLES_LO     = 12;
	localparam int          POS_SLOT0_LO      = 0;
	localparam int          SLOT_W            = 3;
	localparam int          NUM_SLOTS         = 4;
	localparam int          POS_PROT_EN       = 8;
	localparam int          POS_ERR_INJ       = 7;
	localparam int          POS_RB_SEL_LO     = 12;
	localparam int          POS_BYP_SEL_LO    = 0;
	localparam int          NUM_SENSORS       = 5;
	localparam logic [2:0]  SENSOR_TEMP       = 3'h4;
	localparam logic [2:0]  SENSOR_ALL_CHECK  = 3'h7;
	localparam logic [1:0]  SLOT_LAST         = 2'h3;
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_SLOTS  = 2'b01,
		SEQ_ALL    = 2'b10,
		SEQ_BYPASS = 2'b11
	} seq_state_t;
endpackage : monitor_regs_pkg

// File: shared/sensor_bank_if.sv
// carries sensor sample writes and readback selection to the sample store
interface sensor_bank_if;
	logic        wr_en;
	logic [2:0]  wr_idx;
	logic [15:0] wr_data;
	logic [2:0]  rd_idx;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : sensor_bank_if

// File: verilog/sensor_sample_store.sv
// per-sensor latest sample memory with registered read port
module sensor_sample_store #(
	parameter int DEPTH = 5
) (
	input  wire logic    clk_sys,
	input  wire logic    rst,
	input  wire logic    ce,
	sensor_bank_if.store bank
);
	logic [15:0] mem_r   [DEPTH];
	logic [15:0] mem_nxt [DEPTH];
	logic [15:0] rd_r;
	logic [15:0] rd_nxt;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
			if (bank.wr_en && (int'(bank.wr_idx) == i))
				mem_nxt[i] = bank.wr_data;
		end
		// reserved codes read as zero
		rd_nxt = (int'(bank.rd_idx) < DEPTH) ? mem_r[bank.rd_idx] : 16'h0000;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= 16'h0000;
			rd_r <= 16'h0000;
		end else if (ce) begin
			mem_r <= mem_nxt;
			rd_r  <= rd_nxt;
		end
	end

	assign bank.rd_data = rd_r;
endmodule : sensor_sample_store

// File: verilog/sefi_monitor_config_regs.sv
// health monitor configuration registers, slot sequencer and readback path
// Operation
// - gain source bit picks fuse or register gain
// - bypass bit hands sensor control to bypass settings
// - cycle slots count+1 times, then check all
// - four three-bit slot fields choose sensors
// - read-only sixteen-bit sensor readback register
// - protection bit enables register bank ECC
// - inject bit forces protection error when enabled
// - readback select chooses supply or temperature
// - bypass select picks monitored sensor
//
// The strobed register port was chosen for this implementation.
module sefi_monitor_config_regs #(
	parameter int NUM_SENSORS = monitor_regs_pkg::NUM_SENSORS
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [8:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample_data,
	input  wire logic [15:0] fuse_gain,
	output logic      [15:0] sensor_gain,
	output logic      [2:0]  active_sensor,
	output logic             sequencer_active,
	output logic             prot_enable,
	output logic             prot_error_inject,
	output logic             pll_lock_monitor_enable,
	output logic             pll_lock_monitor_force,
	output logic      [2:0]  lock_check_window,
	output logic      [1:0]  lock_check_wait
);
	logic [15:0] seq_cfg_r, seq_cfg_nxt;
	logic [15:0] lock_r, lock_nxt;
	logic [15:0] byp_r, byp_nxt;
	logic [15:0] gain_r, gain_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic        rd_hit_r, rd_hit_nxt;
	logic        rd_is_rb_r, rd_is_rb_nxt;
	monitor_regs_pkg::seq_state_t state_r, state_nxt;
	logic [1:0]  slot_r, slot_nxt;
	logic [1:0]  pass_r, pass_nxt;
	logic [2:0]  all_idx_r, all_idx_nxt;
	logic [2:0]  sensor_r, sensor_nxt;
	logic [2:0]  slot_sel [monitor_regs_pkg::NUM_SLOTS];
	logic        bypass;
	logic [1:0]  cycles;

	sensor_bank_if bank ();

	sensor_sample_store #(
		.DEPTH (NUM_SENSORS)
	) u_store (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.bank    (bank)
	);

	genvar g;
	generate
		for (g = 0; g < monitor_regs_pkg::NUM_SLOTS; g++) begin : g_slot
			assign slot_sel[g] = seq_cfg_r[monitor_regs_pkg::POS_SLOT0_LO
				+ g * monitor_regs_pkg::SLOT_W +: monitor_regs_pkg::SLOT_W];
		end
	endgenerate

	assign bypass = seq_cfg_r[monitor_regs_pkg::POS_BYPASS];
	assign cycles = seq_cfg_r[monitor_regs_pkg::POS_CYCLES_LO +: 2];

	// register writes; readback is read-only so writes there are dropped
	always_comb begin
		seq_cfg_nxt = seq_cfg_r;
		lock_nxt    = lock_r;
		byp_nxt     = byp_r;
		if (reg_wr) begin
			if (reg_addr == monitor_regs_pkg::OFF_SEQ_CFG)
				seq_cfg_nxt = reg_wdata;
			else if (reg_addr == monitor_regs_pkg::OFF_LOCK_PROT)
				lock_nxt = reg_wdata;
			else if (reg_addr == monitor_regs_pkg::OFF_BYPASS_CTRL)
				byp_nxt = reg_wdata;
		end
		gain_nxt = seq_cfg_r[monitor_regs_pkg::POS_GAIN_SRC] ? {8'h00, byp_r[15:8]} : fuse_gain;
	end

	// sequencer: slots 0..3 repeated cycles+1 passes, then a full sweep
	always_comb begin
		state_nxt   = state_r;
		slot_nxt    = slot_r;
		pass_nxt    = pass_r;
		all_idx_nxt = all_idx_r;
		sensor_nxt  = sensor_r;
		case (state_r)
			monitor_regs_pkg::SEQ_IDLE: begin
				slot_nxt  = 2'h0;
				pass_nxt  = 2'h0;
				state_nxt = bypass ? monitor_regs_pkg::SEQ_BYPASS : monitor_regs_pkg::SEQ_SLOTS;
			end
			monitor_regs_pkg::SEQ_SLOTS: begin
				sensor_nxt = slot_sel[slot_r];
				if (bypass)
					state_nxt = monitor_regs_pkg::SEQ_BYPASS;
				else if (sample_valid) begin
					slot_nxt = slot_r + 2'h1;
					if (slot_r == monitor_regs_pkg::SLOT_LAST) begin
						pass_nxt = pass_r + 2'h1;
						if (pass_r == cycles) begin
							state_nxt   = monitor_regs_pkg::SEQ_ALL;
							all_idx_nxt = 3'h0;
						end
					end
				end
			end
			monitor_regs_pkg::SEQ_ALL: begin
				sensor_nxt = all_idx_r;
				if (bypass)
					state_nxt = monitor_regs_pkg::SEQ_BYPASS;
				else if (sample_valid) begin
					all_idx_nxt = all_idx_r + 3'h1;
					if (all_idx_r == monitor_regs_pkg::SENSOR_TEMP)
						state_nxt = monitor_regs_pkg::SEQ_IDLE;
				end
			end
			monitor_regs_pkg::SEQ_BYPASS: begin
				sensor_nxt = byp_r[monitor_regs_pkg::POS_BYP_SEL_LO +: 3];
				if (!bypass)
					state_nxt = monitor_regs_pkg::SEQ_IDLE;
			end
			default: state_nxt = monitor_regs_pkg::SEQ_IDLE;
		endcase
	end

	// read path; readback data arrives from the store one cycle later
	always_comb begin
		rd_hit_nxt   = reg_rd;
		rd_is_rb_nxt = reg_rd && (reg_addr == monitor_regs_pkg::OFF_READBACK);
		rdata_nxt    = 16'h0000;
		if (reg_addr == monitor_regs_pkg::OFF_SEQ_CFG)
			rdata_nxt = seq_cfg_r;
		else if (reg_addr == monitor_regs_pkg::OFF_LOCK_PROT)
			rdata_nxt = lock_r;
		else if (reg_addr == monitor_regs_pkg::OFF_BYPASS_CTRL)
			rdata_nxt = byp_r;
		if (!reg_rd)
			rdata_nxt = 16'h0000;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seq_cfg_r  <= monitor_regs_pkg::RST_SEQ_CFG;
			lock_r     <= monitor_regs_pkg::RST_LOCK_PROT;
			byp_r      <= monitor_regs_pkg::RST_BYPASS_CTRL;
			gain_r     <= 16'h0000;
			rdata_r    <= 16'h0000;
			rd_hit_r   <= 1'b0;
			rd_is_rb_r <= 1'b0;
			state_r    <= monitor_regs_pkg::SEQ_IDLE;
			slot_r     <= 2'h0;
			pass_r     <= 2'h0;
			all_idx_r  <= 3'h0;
			sensor_r   <= 3'h0;
		end else if (ce) begin
			seq_cfg_r  <= seq_cfg_nxt;
			lock_r     <= lock_nxt;
			byp_r      <= byp_nxt;
			gain_r     <= gain_nxt;
			rdata_r    <= rdata_nxt;
			rd_hit_r   <= rd_hit_nxt;
			rd_is_rb_r <= rd_is_rb_nxt;
			state_r    <= state_nxt;
			slot_r     <= slot_nxt;
			pass_r     <= pass_nxt;
			all_idx_r  <= all_idx_nxt;
			sensor_r   <= sensor_nxt;
		end
	end

	// samples land at the slot of the sensor being measured
	assign bank.wr_en   = sample_valid && (sensor_r < monitor_regs_pkg::SENSOR_ALL_CHECK);
	assign bank.wr_idx  = sensor_r;
	assign bank.wr_data = sample_data;
	assign bank.rd_idx  = byp_r[monitor_regs_pkg::POS_RB_SEL_LO +: 3];

	assign reg_rdata = rd_is_rb_r ? bank.rd_data : rdata_r;

	assign sensor_gain       = gain_r;
	assign active_sensor     = sensor_r;
	assign sequencer_active  = (state_r != monitor_regs_pkg::SEQ_BYPASS);
	assign prot_enable       = lock_r[monitor_regs_pkg::POS_PROT_EN];
	// injection only matters while protection is on
	assign prot_error_inject = lock_r[monitor_regs_pkg::POS_PROT_EN]
		&& lock_r[monitor_regs_pkg::POS_ERR_INJ];
	assign pll_lock_monitor_enable = lock_r[0];
	assign pll_lock_monitor_force  = lock_r[1];
	assign lock_check_window       = lock_r[6:4];
	assign lock_check_wait         = lock_r[3:2];

	a_readonly_rb: assert property (@(posedge clk_sys) disable iff (rst)
		ce && reg_wr && reg_addr == monitor_regs_pkg::OFF_READBACK |=> $stable(seq_cfg_r))
		else $error("write to readback changed config");
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!rd_hit_r |-> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	a_inject_gated: assert property (@(posedge clk_sys) disable iff (rst)
		ce && reg_wr && reg_addr == monitor_regs_pkg::OFF_LOCK_PROT
		|=> prot_error_inject == ($past(reg_wdata[monitor_regs_pkg::POS_PROT_EN])
		&& $past(reg_wdata[monitor_regs_pkg::POS_ERR_INJ])))
		else $error("inject not gated by protection");
	a_bypass_sel: assert property (@(posedge clk_sys) disable iff (rst)
		ce && state_r == monitor_regs_pkg::SEQ_BYPASS && bypass
		|=> active_sensor == $past(byp_r[2:0]))
		else $error("bypass sensor mismatch");
	a_bypass_enter: assert property (@(posedge clk_sys) disable iff (rst)
		ce && bypass && state_r != monitor_regs_pkg::SEQ_BYPASS |=> !ce || !bypass
		|| state_r == monitor_regs_pkg::SEQ_BYPASS)
		else $error("bypass not entered");
	// the edge that releases reset still runs the reset branch, so it starts no attempt
	a_gain_src: assert property (@(posedge clk_sys) disable iff (rst)
		!rst && ce && !seq_cfg_r[15] |=> !ce || sensor_gain == $past(fuse_gain))
		else $error("gain not from fuse");
	a_slot_pick: assert property (@(posedge clk_sys) disable iff (rst)
		ce && state_r == monitor_regs_pkg::SEQ_SLOTS && !bypass |=> !ce
		|| active_sensor == $past(slot_sel[slot_r]))
		else $error("slot sensor mismatch");
	a_all_after: assert property (@(posedge clk_sys) disable iff (rst)
		ce && state_r == monitor_regs_pkg::SEQ_SLOTS && !bypass && sample_valid
		&& slot_r == 2'h3 && pass_r == cycles |=> state_r == monitor_regs_pkg::SEQ_ALL)
		else $error("full check not started");
	a_store_write: assert property (@(posedge clk_sys) disable iff (rst)
		ce && reg_wr && reg_addr == monitor_regs_pkg::OFF_LOCK_PROT
		|=> lock_r == $past(reg_wdata))
		else $error("lock register not stored");
	a_prot_bit: assert property (@(posedge clk_sys) disable iff (rst)
		ce && reg_wr && reg_addr == monitor_regs_pkg::OFF_LOCK_PROT
		|=> prot_enable == $past(reg_wdata[monitor_regs_pkg::POS_PROT_EN]))
		else $error("protection enable mismatch");
	c_full_sweep: cover property (@(posedge clk_sys) state_r == monitor_regs_pkg::SEQ_ALL);
	c_bypass: cover property (@(posedge clk_sys) state_r == monitor_regs_pkg::SEQ_BYPASS);
	c_rb_read: cover property (@(posedge clk_sys) rd_is_rb_r && reg_rdata != 16'h0000);
	c_inject: cover property (@(posedge clk_sys) prot_error_inject);
endmodule : sefi_monitor_config_regs

// File: tb/sensor_source_model.sv
// sensor adc stand-in: pulses a sample every fourth cycle while enabled
module sensor_source_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        en,
	input  wire logic [2:0]  active_sensor,
	output logic             sample_valid,
	output logic      [15:0] sample_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tick_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_r <= 2'h0;
			sample_valid <= 1'b0;
			sample_data <= 16'h0000;
		end else begin
			tick_r <= en ? tick_r + 2'h1 : 2'h0;
			sample_valid <= en && (tick_r == 2'h3);
			// value tags the sensor so readback shows which slot was stored
			sample_data <= (en && (tick_r == 2'h3)) ? (16'h9c40 | active_sensor) : ~sample_data;
		end
	end
endmodule : sensor_source_model

// File: tb/sefi_monitor_config_regs_tb.sv
// self-checking bench for the health monitor register bank
module sefi_monitor_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [8:0]  reg_addr = 9'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata, sample_data, fuse_gain = 16'h0000, sensor_gain;
	logic [2:0]  active_sensor, lock_check_window;
	logic [1:0]  lock_check_wait;
	logic        sample_valid, sequencer_active, prot_enable, prot_error_inject;
	logic        pll_lock_monitor_enable, pll_lock_monitor_force, src_en = 1'b0;
	integer      bad_count = 0, total_checks = 0, seed = 32'h5f0e209d, i, n;
	logic [15:0] v;
	logic [2:0]  seq_exp [13] = '{3'h3, 3'h0, 3'h2, 3'h4, 3'h3, 3'h0, 3'h2, 3'h4,
		3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
	always #20 clk_sys = ~clk_sys;
	sefi_monitor_config_regs u_sefi_monitor_config_regs (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample_data(sample_data), .fuse_gain(fuse_gain), .sensor_gain(sensor_gain),
		.active_sensor(active_sensor), .sequencer_active(sequencer_active),
		.prot_enable(prot_enable), .prot_error_inject(prot_error_inject),
		.pll_lock_monitor_enable(pll_lock_monitor_enable),
		.pll_lock_monitor_force(pll_lock_monitor_force),
		.lock_check_window(lock_check_window), .lock_check_wait(lock_check_wait));
	sensor_source_model u_sensor_source_model (.clk_sys(clk_sys), .rst(rst), .en(src_en),
		.active_sensor(active_sensor), .sample_valid(sample_valid), .sample_data(sample_data));
	function automatic logic [15:0] sample_of(input logic [2:0] k);
		return (k > 3'h4) ? 16'h0000 : (16'h9c40 | k);
	endfunction : sample_of
	function automatic logic [15:0] lock_outs(input logic [15:0] w);
		return {7'h0, w[8], w[8] & w[7], w[6:4], w[3:2], w[1], w[0]};
	endfunction : lock_outs
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input string what, input logic [8:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(what, exp, reg_rdata);
	endtask : rd_chk
	task automatic results;
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
	endtask : do_reset
	initial begin
		#(40 * 20000);
		bad_count++;
		results();
	end
	initial begin
		do_reset();
		rd_chk("seq_cfg", 9'h1e9, 16'h036d);
		rd_chk("lock", 9'h1ee, 16'h0035);
		rd_chk("readback", 9'h1ea, 16'h0000);
		rd_chk("unmapped", 9'h1f3, 16'h0000);
		chk("lock_outs", lock_outs(16'h0035), {7'h0, prot_enable, prot_error_inject,
			lock_check_window, lock_check_wait, pll_lock_monitor_force,
			pll_lock_monitor_enable});
		chk("seq_active_rst", 16'h0001, {15'h0, sequencer_active});
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 16'h0180 : (i == 1) ? 16'h0080 : 16'($random(seed));
			wr(9'h1ee, v);
			rd_chk("lock_rw", 9'h1ee, v);
			chk("lock_outs", lock_outs(v), {7'h0, prot_enable, prot_error_inject,
				lock_check_window, lock_check_wait, pll_lock_monitor_force,
				pll_lock_monitor_enable});
			chk("prot_en", {15'h0, v[8]}, {15'h0, prot_enable});
		end
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(9'h1ee, 16'h0000);
		ce <= 1'b1;
		rd_chk("ce_low", 9'h1ee, v);
		@(posedge clk_sys);
		fuse_gain <= 16'($random(seed));
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("gain_fuse", fuse_gain, sensor_gain);
		wr(9'h1e8, 16'ha700);
		wr(9'h1e9, 16'h836d);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("gain_reg", 16'h00a7, sensor_gain);
		wr(9'h1e9, 16'h4000);
		for (i = 0; i < 8; i++) begin
			wr(9'h1e8, 16'(i << 12) | 16'(i % 5));
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("bypass_sel", 16'(i % 5), {13'h0, active_sensor});
			chk("seq_active", 16'h0000, {15'h0, sequencer_active});
			src_en <= 1'b1;
			repeat (8) @(posedge clk_sys);
			src_en <= 1'b0;
			rd_chk("readback", 9'h1ea, sample_of(3'(i)));
		end
		wr(9'h1e8, 16'h0000);
		wr(9'h1ea, 16'hffff);
		rd_chk("ro_readback", 9'h1ea, sample_of(3'h0));
		@(posedge clk_sys);
		do_reset();
		wr(9'h1e9, 16'h1883);
		repeat (4) @(posedge clk_sys);
		src_en <= 1'b1;
		for (i = 0; i < 13; i++) begin
			n = 0;
			@(negedge clk_sys);
			while (sample_valid !== 1'b1 && n < 20) begin
				@(negedge clk_sys);
				n++;
			end
			chk("slot_seq", {13'h0, seq_exp[i]}, {13'h0, active_sensor});
			chk("slot_valid", 16'h0001, {15'h0, sample_valid});
		end
		src_en <= 1'b0;
		results();
	end
endmodule : sefi_monitor_config_regs_tb
